// ===== core/rbf_pkg.sv
/*
 Shared definitions for the battery-low and century flag block.
 Assumes a byte-wide register port with 13-bit addresses and one clock.
*/
package rbf_pkg;
   localparam int unsigned ADDR_W = 13;
   localparam int unsigned DATA_W = 8;
   localparam logic [12:0] ADDR_CONTROL   = 13'h1FF8;
   localparam logic [12:0] ADDR_CENTURY   = 13'h1FFC;
   localparam logic [12:0] ADDR_DATE      = 13'h1FFD;
   localparam logic [12:0] ADDR_IRQ_STAT  = 13'h1FF0;
   localparam logic [12:0] ADDR_IRQ_MASK  = 13'h1FF1;
   localparam int unsigned BIT_HALT_WRITE = 7;
   localparam int unsigned BIT_BAT_EN     = 7;
   localparam int unsigned BIT_BAT_LOW    = 6;
   localparam int unsigned BIT_CENT_EN    = 5;
   localparam int unsigned BIT_CENT_FLAG  = 4;
   localparam int unsigned IRQ_BAT_LOW    = 0;
   localparam int unsigned IRQ_CENTURY    = 1;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   localparam logic [1:0]  IRQ_ZERO       = 2'h0;

   typedef struct packed {
      logic [12:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } rbf_bus_t;

   typedef struct packed {
      logic        halt_write;
      logic        bat_en;
      logic        bat_low;
      logic        cent_en;
      logic        cent_flag;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic [7:0]  rdata;
      logic        irq;
      logic [1:0]  sup_sync;
      logic        sup_seen;
      logic [1:0]  bat_sync;
      logic [1:0]  roll_sync;
      logic        roll_prev;
   } rbf_state_t;
endpackage : rbf_pkg

// ===== core/rbf_flags.sv
/*
 Battery-low monitor and century flag with their register port.
 Assumes pins for supply-good, battery-low comparator and century rollover
 come from outside the clock domain; the host uses the one-cycle strobe port.
*/
// The plain strobed port is this design's own decision.
//
// Behaviour
// - Battery low flag is bit 6 at 1FFDh, set when battery measured low.
// - Battery low flag rises only when battery low enable is one.
// - Battery low flag is sticky until a later test finds battery good.
// - Battery test runs at power-up only, while main supply is good.
// - Century enable is bit 5, century flag bit 4, of 1FFCh.
// - With century enable set, the flag inverts on each century rollover.
// - With century enable clear, the flag holds at rollover.
// - Host writes to the century flag land only while write-halt is set.
// - Battery low flag is read-only to the host.
// - Write-halt control is bit 7 of the control register at 1FF8h.
`timescale 1ns/1ps
`default_nettype none
module rbf_flags
   import rbf_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            resetn,
   input  wire rbf_pkg::rbf_bus_t bus,
   input  wire logic            supply_good,
   input  wire logic            battery_below,
   input  wire logic            century_rollover,
   output logic [7:0]           rdata,
   output logic                 irq
);
   import rbf_pkg::*;

   rbf_state_t s_reg;
   rbf_state_t s_next;

   always_comb begin
      logic wr_ctl;
      logic wr_cen;
      logic wr_dat;
      logic test_now;
      logic roll;
      logic [1:0] ev;
      s_next   = s_reg;
      roll     = 1'b0;
      test_now = 1'b0;
      wr_ctl   = bus.wr && bus.addr == ADDR_CONTROL;
      wr_cen   = bus.wr && bus.addr == ADDR_CENTURY;
      wr_dat   = bus.wr && bus.addr == ADDR_DATE;
      ev       = IRQ_ZERO;
      s_next.sup_sync  = {s_reg.sup_sync[0], supply_good};
      s_next.bat_sync  = {s_reg.bat_sync[0], battery_below};
      s_next.roll_sync = {s_reg.roll_sync[0], century_rollover};
      s_next.roll_prev = s_reg.roll_sync[1];
      roll     = s_reg.roll_sync[1] && !s_reg.roll_prev;
      test_now = s_reg.sup_sync[1] && !s_reg.sup_seen;
      if (!s_reg.sup_sync[1]) begin
         s_next.sup_seen = 1'b0;
      end else begin
         s_next.sup_seen = 1'b1;
      end
      if (wr_ctl) begin
         s_next.halt_write = bus.wdata[BIT_HALT_WRITE];
      end
      if (wr_dat) begin
         s_next.bat_en = bus.wdata[BIT_BAT_EN];
      end
      if (test_now) begin
         if (s_reg.bat_sync[1] && s_reg.bat_en) begin
            s_next.bat_low = 1'b1;
            ev[IRQ_BAT_LOW] = 1'b1;
         end else if (!s_reg.bat_sync[1]) begin
            s_next.bat_low = 1'b0;
         end
      end
      if (wr_cen) begin
         s_next.cent_en = bus.wdata[BIT_CENT_EN];
         if (s_reg.halt_write) begin
            s_next.cent_flag = bus.wdata[BIT_CENT_FLAG];
         end
      end
      if (roll && s_reg.cent_en) begin
         s_next.cent_flag = ~s_next.cent_flag;
         ev[IRQ_CENTURY] = 1'b1;
      end
      if (bus.wr && bus.addr == ADDR_IRQ_MASK) begin
         s_next.irq_mask = bus.wdata[1:0];
      end
      if (bus.wr && bus.addr == ADDR_IRQ_STAT) begin
         s_next.irq_stat = s_reg.irq_stat & ~bus.wdata[1:0];
      end
      s_next.irq_stat = s_next.irq_stat | ev;
      s_next.irq   = |(s_next.irq_stat & s_next.irq_mask);
      s_next.rdata = RESET_BYTE;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_CONTROL: s_next.rdata[BIT_HALT_WRITE] = s_reg.halt_write;
            ADDR_CENTURY: begin
               s_next.rdata[BIT_CENT_EN]   = s_reg.cent_en;
               s_next.rdata[BIT_CENT_FLAG] = s_reg.cent_flag;
            end
            ADDR_DATE: begin
               s_next.rdata[BIT_BAT_EN]  = s_reg.bat_en;
               s_next.rdata[BIT_BAT_LOW] = s_reg.bat_low;
            end
            ADDR_IRQ_STAT: s_next.rdata[1:0] = s_reg.irq_stat;
            ADDR_IRQ_MASK: s_next.rdata[1:0] = s_reg.irq_mask;
            default:       s_next.rdata = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign irq   = s_reg.irq;
endmodule : rbf_flags
`default_nettype wire

// ===== test/rbf_properties.sv
/* Port checker for rbf_flags. Assumes the bench keeps inputs quiet around clears. */
`timescale 1ns/1ps
`default_nettype none
module rbf_props
   import rbf_pkg::*;
(
   input wire logic              clock,
   input wire logic              resetn,
   input wire rbf_pkg::rbf_bus_t bus,
   input wire logic [7:0]        rdata,
   input wire logic              irq
);
   logic        rq;
   logic [12:0] aq;
   always_ff @(posedge clock) begin
      rq <= bus.rd;
      aq <= bus.addr;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_idle_read_zero: assert property (!rq |-> rdata == 8'h00) else $error("rdata idle");
   a_date_layout: assert property (rq && aq == ADDR_DATE |-> rdata[5:0] == 6'h00)
      else $error("date bits");
   a_century_layout: assert property (rq && aq == ADDR_CENTURY |-> (rdata & 8'hCF) == 8'h00)
      else $error("century bits");
   a_halt_layout: assert property (rq && aq == ADDR_CONTROL |-> rdata[6:0] == 7'h00)
      else $error("control bits");
   a_status_layout: assert property (rq && aq[12:1] == 12'hFF8 |-> rdata[7:2] == 6'h00)
      else $error("status bits");
   a_unmapped_zero: assert property (rq && aq < 13'h1FF0 |-> rdata == 8'h00) else $error("unmapped");
   a_clear_drops_irq: assert property (bus.wr && bus.addr == ADDR_IRQ_STAT && bus.wdata == 8'h03
      |-> ##2 !irq) else $error("irq after clear");
   a_mask_drops_irq: assert property (bus.wr && bus.addr == ADDR_IRQ_MASK && bus.wdata == 8'h00
      |-> ##2 !irq) else $error("irq after mask");
   cover property (irq);
   cover property (rq && aq == ADDR_DATE && rdata[6]);
   cover property (rq && aq == ADDR_CENTURY && rdata[4]);
endmodule : rbf_props
bind rbf_flags rbf_props rbf_props_i (.clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata),
   .irq(irq));
`default_nettype wire

// ===== test/rbf_host.sv
/* Host bus model with write and read tasks. Assumes one clock and read data a cycle late. */
`timescale 1ns/1ps
`default_nettype none
module rbf_host
   import rbf_pkg::*;
(
   input  wire logic [7:0]        rdata,
   input  wire logic              clock,
   output var rbf_pkg::rbf_bus_t  bus
);
   initial bus = '0;
   task automatic put(input logic [12:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask : put
   task automatic get(input logic [12:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : get
endmodule : rbf_host
`default_nettype wire

// ===== test/rbf_flags_test.sv
/* Self-checking bench for rbf_flags. Assumes rbf_host drives the register bus. */
`timescale 1ns/1ps
`default_nettype none
module rbf_flags_test;
   import rbf_pkg::*;
   logic        clock = 0, resetn = 0, sup = 0, bat = 0, roll = 0, irq;
   logic [7:0]  rdata, d;
   logic [12:0] a;
   rbf_bus_t    bus;
   int          bad_count = 0, total_checks = 0, cyc = 0, seed = 32'h99da;
   rbf_flags rbf_flags_i (.clock(clock), .resetn(resetn), .bus(bus), .supply_good(sup),
      .battery_below(bat), .century_rollover(roll), .rdata(rdata), .irq(irq));
   rbf_host rbf_host_i (.rdata(rdata), .clock(clock), .bus(bus));
   initial forever #25 clock = ~clock;
   function automatic logic [7:0] cent(logic en, logic fl);
      return {2'h0, en, fl, 4'h0};
   endfunction : cent
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic rc(input logic [12:0] ad, input logic [7:0] e);
      rbf_host_i.get(ad, d);
      chk(d, e);
   endtask : rc
   task automatic power(input logic b);
      @(posedge clock) {sup, bat} <= {1'b0, b};
      repeat (4) @(posedge clock);
      sup <= 1'b1;
      repeat (8) @(posedge clock);
   endtask : power
   task automatic turn;
      @(posedge clock) roll <= 1'b1;
      repeat (5) @(posedge clock);
      roll <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : turn
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   always @(posedge clock) if (++cyc == 3000) begin
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      for (a = ADDR_IRQ_STAT; a < 13'h1FFE; a++) rc(a, 8'h00);
      rbf_host_i.put(ADDR_IRQ_MASK, 8'h03);
      rbf_host_i.put(ADDR_CENTURY, 8'h30);
      rc(ADDR_CENTURY, cent(1, 0));
      rbf_host_i.put(ADDR_CONTROL, 8'h80);
      rbf_host_i.put(ADDR_CENTURY, 8'h30);
      rc(ADDR_CONTROL, 8'h80);
      rbf_host_i.put(ADDR_CONTROL, 8'h00);
      rc(ADDR_CENTURY, cent(1, 1));
      turn();
      rc(ADDR_CENTURY, cent(1, 0));
      rc(ADDR_IRQ_STAT, 8'h02);
      rbf_host_i.put(ADDR_IRQ_STAT, 8'h03);
      rbf_host_i.put(ADDR_CENTURY, 8'h10);
      turn();
      rc(ADDR_CENTURY, cent(0, 0));
      power(1);
      rc(ADDR_DATE, 8'h00);
      rbf_host_i.put(ADDR_DATE, 8'h80);
      power(1);
      rc(ADDR_DATE, 8'hC0);
      chk({7'h0, irq}, 8'h01);
      @(posedge clock) bat <= 1'b0;
      repeat (8) @(posedge clock);
      rbf_host_i.put(ADDR_DATE, 8'h00);
      rc(ADDR_DATE, 8'h40);
      rbf_host_i.put(ADDR_IRQ_MASK, 8'h00);
      rc(ADDR_IRQ_MASK, 8'h00);
      chk({7'h0, irq}, 8'h00);
      power(0);
      rc(ADDR_DATE, 8'h00);
      repeat (6) begin
         a = 13'($random(seed)) & 13'h0FFF;
         rbf_host_i.put(a, 8'($random(seed)));
         rc(a, 8'h00);
      end
      wrap_up();
   end
endmodule : rbf_flags_test
`default_nettype wire
